// ### core/fcct_top.v
// Four channel counter/timer with daisy-chain vectored interrupts
// Operation
// - Control byte, time constant, optional vector
// - Bit7 enables channel interrupts
// - Bit6 counter else timer mode
// - Bit5 prescale 256 else 16
// - Bit4 rising else falling edge
// - Bit3 external trigger starts timer
// - Bit2 announces time constant next
// - Bit1 software resets channel
// - Time constant follows control, 1-256
// - Load at start, reload at zero
// - New constant used after current countdown
// - Decrement on edge or prescaler pulse
// - Period is clock times prescale times constant
// - Read returns down-counter value
// - Channels 0-2 pulse zero-count output
// - Enabled channel requests interrupt at zero
// - Channel 0 highest, 3 lowest priority
// - Only higher priority nests over service
// - Channel number inserted into vector
// - Select inputs form channel number
// - Acknowledge drives base, channel, zero
// - Chain out low while servicing; return ends
// - Reset stops channels, clears outputs except chain out, which follows chain in
`default_nettype none
`include "fcct_defines.vh"

module fcct_top (
  input wire clk,
  input wire rst,
  input wire chip_en_n,
  input wire iorq_n,
  input wire rd_n,
  input wire m1_n,
  input wire chan_sel_lo,
  input wire chan_sel_hi,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  input wire [3:0] ext_clock_trigger,
  output reg [2:0] zero_count_pulse,
  output reg irq_n_out,
  output reg irq_oe,
  input wire chain_enable_in,
  output reg chain_enable_out
);

  // ****************************************
  // Bus decode
  // ****************************************
  wire [1:0] sel; // Channel number
  wire io_cyc; // Chip I/O cycle
  wire wr_cyc; // Write cycle
  wire rd_cyc; // Read cycle
  wire ack_cyc; // Interrupt acknowledge
  reg wr_prev_q; // Write seen last cycle
  reg ack_prev_q; // Acknowledge seen last cycle
  reg return_from_irq_opcode_pre_q; // Prefix of return seen
  wire [3:0] ch_wr;
  wire [7:0] cnt0;
  wire [7:0] cnt1;
  wire [7:0] cnt2;
  wire [7:0] cnt3;
  wire [7:0] ctl0;
  wire [7:0] ctl1;
  wire [7:0] ctl2;
  wire [7:0] ctl3;
  wire [3:0] zero;
  wire [3:0] ie;
  reg [7:0] vec_q; // Vector base
  reg [3:0] pend_q; // Pending requests
  reg [3:0] serv_q; // Under service
  reg [7:0] count_mux;
  wire vec_wr;
  wire [1:0] win;
  wire any_req;
  wire return_from_irq_opcode_seen;
  wire [3:0] blocked;
  wire [3:0] ack_clr;

  assign sel = {chan_sel_hi, chan_sel_lo};
  assign io_cyc = !chip_en_n && !iorq_n && m1_n;
  assign wr_cyc = io_cyc && rd_n;
  assign rd_cyc = io_cyc && !rd_n;
  assign ack_cyc = !iorq_n && !m1_n;

  // One write per bus cycle, taken at its first clock
  wire wr_take;
  assign wr_take = wr_cyc && !wr_prev_q;

  // Vector byte: bit0 zero, not a pending time constant
  wire [3:0] tc_pending;
  assign vec_wr = wr_take && !data_in[`FCCT_CW_IS_CTRL] && !tc_pending[sel];

  // ****************************************
  // Channel instances
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
      assign ch_wr[g] = wr_take && (sel == g) && !vec_wr;
    end
  endgenerate

  fcct_channel u_ch0 (.clk(clk), .rst(rst), .wr_en(ch_wr[0]), .wr_data(data_in),
    .ext_in(ext_clock_trigger[0]), .count_q(cnt0), .ctrl_q(ctl0), .zero_q(zero[0]));
  fcct_channel u_ch1 (.clk(clk), .rst(rst), .wr_en(ch_wr[1]), .wr_data(data_in),
    .ext_in(ext_clock_trigger[1]), .count_q(cnt1), .ctrl_q(ctl1), .zero_q(zero[1]));
  fcct_channel u_ch2 (.clk(clk), .rst(rst), .wr_en(ch_wr[2]), .wr_data(data_in),
    .ext_in(ext_clock_trigger[2]), .count_q(cnt2), .ctrl_q(ctl2), .zero_q(zero[2]));
  fcct_channel u_ch3 (.clk(clk), .rst(rst), .wr_en(ch_wr[3]), .wr_data(data_in),
    .ext_in(ext_clock_trigger[3]), .count_q(cnt3), .ctrl_q(ctl3), .zero_q(zero[3]));

  // Time-constant expectation mirrored per channel
  reg [3:0] tcp_q;
  assign tc_pending = tcp_q;
  always @(posedge clk)
  begin
    if (rst)
      tcp_q <= 4'h0;
    else if (wr_take && !vec_wr)
      tcp_q[sel] <= tcp_q[sel] ? 1'b0 : data_in[`FCCT_CW_TC_FOLLOWS];
  end

  assign ie = {ctl3[`FCCT_CW_IRQ_EN], ctl2[`FCCT_CW_IRQ_EN],
               ctl1[`FCCT_CW_IRQ_EN], ctl0[`FCCT_CW_IRQ_EN]};

  // ****************************************
  // Priority resolution
  // ****************************************
  // Lowest index wins among requests
  function [1:0] first_set;
    input [3:0] v;
    begin
      if (v[0])
        first_set = 2'd0;
      else if (v[1])
        first_set = 2'd1;
      else if (v[2])
        first_set = 2'd2;
      else
        first_set = 2'd3;
    end
  endfunction

  // A request is blocked by service at equal or higher priority
  assign blocked[0] = serv_q[0];
  assign blocked[1] = |serv_q[1:0];
  assign blocked[2] = |serv_q[2:0];
  assign blocked[3] = |serv_q[3:0];
  wire [3:0] live;
  assign live = pend_q & ~blocked;
  assign win = first_set(live);
  assign any_req = |live && chain_enable_in;

  // Return opcode pair decoded from fetch cycles
  wire fetch;
  assign fetch = !m1_n && !rd_n && iorq_n;
  assign return_from_irq_opcode_seen = fetch && return_from_irq_opcode_pre_q && (data_in == `FCCT_RETURN_FROM_IRQ_OPCODE_SECOND);

  // Acknowledge accepted once per cycle
  wire ack_take;
  assign ack_take = ack_cyc && !ack_prev_q && chain_enable_in && (|live);
  assign ack_clr = ack_take ? (4'h1 << win) : 4'h0;

  // ****************************************
  // Interrupt state
  // ****************************************
  always @(posedge clk)
  begin
    wr_prev_q <= wr_cyc;
    ack_prev_q <= ack_cyc;
    if (rst)
    begin
      vec_q <= `FCCT_VEC_RESET;
      pend_q <= 4'h0;
      serv_q <= 4'h0;
      return_from_irq_opcode_pre_q <= 1'b0;
    end
    else
    begin
      if (vec_wr)
        vec_q <= data_in;
      // New zero events win over the acknowledge clear
      pend_q <= (pend_q & ~ack_clr & ie) | (zero & ie);
      if (fetch)
        return_from_irq_opcode_pre_q <= (data_in == `FCCT_RETURN_FROM_IRQ_OPCODE_PREFIX);
      if (ack_take)
        serv_q <= serv_q | ack_clr;
      else if (return_from_irq_opcode_seen)
        serv_q <= serv_q & ~(4'h1 << first_set(serv_q));
    end
  end

  // Read data selection
  always @*
  begin
    case (sel)
      2'd0: count_mux = cnt0;
      2'd1: count_mux = cnt1;
      2'd2: count_mux = cnt2;
      2'd3: count_mux = cnt3;
      default: count_mux = 8'h00;
    endcase
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      zero_count_pulse <= 3'h0;
      irq_n_out <= 1'b0;
      irq_oe <= 1'b0;
      chain_enable_out <= chain_enable_in;
    end
    else
    begin
      zero_count_pulse <= zero[2:0];
      irq_n_out <= 1'b0;
      irq_oe <= any_req;
      chain_enable_out <= chain_enable_in && !(|serv_q);
      if (ack_cyc && chain_enable_in && (|live))
      begin
        data_out <= {vec_q[7:3], win, 1'b0};
        data_oe <= 1'b1;
      end
      else if (rd_cyc)
      begin
        data_out <= count_mux;
        data_oe <= 1'b1;
      end
      else
      begin
        data_out <= 8'h00;
        data_oe <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/fcct_defines.vh
// Constants for the four channel counter/timer
`ifndef FCCT_DEFINES_VH
`define FCCT_DEFINES_VH

// ****************************************
// Control word fields
// ****************************************
`define FCCT_CW_IRQ_EN 7
`define FCCT_CW_MODE 6
`define FCCT_CW_PRESCALE 5
`define FCCT_CW_EDGE 4
`define FCCT_CW_TRIG 3
`define FCCT_CW_TC_FOLLOWS 2
`define FCCT_CW_SW_RESET 1
`define FCCT_CW_IS_CTRL 0

// ****************************************
// Reset values and timing
// ****************************************
`define FCCT_CTRL_RESET 8'h00
`define FCCT_VEC_RESET 8'h00
`define FCCT_DIV_SHORT 16
`define FCCT_DIV_LONG 256
`define FCCT_RETURN_FROM_IRQ_OPCODE_PREFIX 8'hed
`define FCCT_RETURN_FROM_IRQ_OPCODE_SECOND 8'h4d

`endif

// ### core/fcct_prescaler.v
// Prescaler giving one-cycle enable pulses every 16 or 256 clocks
`default_nettype none
`include "fcct_defines.vh"

module fcct_prescaler #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire clr,
  input wire run,
  input wire long_div,
  output wire tick
);

  // ****************************************
  // Free-running divider
  // ****************************************
  reg [WIDTH-1:0] cnt_q; // Cycle count within a period

  // Count while running, restart on clear
  always @(posedge clk)
  begin
    if (clr || !run)
      cnt_q <= {WIDTH{1'b0}};
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // Pulse at the last cycle of a 16 or 256 period
  assign tick = run && (long_div ? (&cnt_q) : (&cnt_q[3:0]));

endmodule
`default_nettype wire

// ### core/fcct_channel.v
// One counter/timer channel: control, reload, down-counter
`default_nettype none
`include "fcct_defines.vh"

module fcct_channel (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire ext_in,
  output reg [7:0] count_q,
  output reg [7:0] ctrl_q,
  output reg zero_q
);

  // ****************************************
  // State
  // ****************************************
  reg [7:0] reload_q; // Time constant
  reg tc_next_q; // Next write is a time constant
  reg loaded_q; // Time constant present
  reg armed_q; // Waiting for trigger edge
  reg run_q; // Counting
  reg ext_q; // Previous input level
  wire edge_rise;
  wire edge_fall;
  wire edge_hit;
  wire tick;
  wire dec;
  wire is_ctrl;

  assign edge_rise = ext_in && !ext_q;
  assign edge_fall = !ext_in && ext_q;
  assign edge_hit = ctrl_q[`FCCT_CW_EDGE] ? edge_rise : edge_fall;
  assign is_ctrl = wr_data[`FCCT_CW_IS_CTRL] && !tc_next_q;

  // Prescaler for timer mode
  fcct_prescaler #(.WIDTH(8)) u_pre (
    .clk(clk),
    .clr(rst),
    .run(run_q && !ctrl_q[`FCCT_CW_MODE]),
    .long_div(ctrl_q[`FCCT_CW_PRESCALE]),
    .tick(tick)
  );

  // Decrement source by mode
  assign dec = run_q && (ctrl_q[`FCCT_CW_MODE] ? edge_hit : tick);

  // ****************************************
  // Channel sequencing
  // ****************************************
  always @(posedge clk)
  begin
    ext_q <= ext_in;
    zero_q <= 1'b0;
    if (rst)
    begin
      ctrl_q <= `FCCT_CTRL_RESET;
      reload_q <= 8'h00;
      count_q <= 8'h00;
      tc_next_q <= 1'b0;
      loaded_q <= 1'b0;
      armed_q <= 1'b0;
      run_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (wr_en && tc_next_q)
    begin
      // Time constant byte
      reload_q <= wr_data;
      tc_next_q <= 1'b0;
      loaded_q <= 1'b1;
      if (!run_q && !armed_q)
      begin
        count_q <= wr_data;
        if (!ctrl_q[`FCCT_CW_MODE] && ctrl_q[`FCCT_CW_TRIG])
          armed_q <= 1'b1;
        else
          run_q <= 1'b1;
      end
    end
    else if (wr_en && is_ctrl)
    begin
      // Control byte
      ctrl_q <= wr_data;
      tc_next_q <= wr_data[`FCCT_CW_TC_FOLLOWS];
      if (wr_data[`FCCT_CW_SW_RESET])
      begin
        run_q <= 1'b0;
        armed_q <= 1'b0;
        loaded_q <= 1'b0;
      end
    end
    else
    begin
      if (armed_q && edge_hit)
      begin
        armed_q <= 1'b0;
        run_q <= 1'b1;
      end
      if (dec)
      begin
        if (count_q == 8'h01)
        begin
          count_q <= reload_q;
          zero_q <= 1'b1;
        end
        else
          count_q <= count_q - 8'h01; // 0 wraps to 255 for 256
      end
    end
  end

endmodule
`default_nettype wire

// ### sim/fcct_properties.sv
// Port-level checks for the four channel counter/timer
`default_nettype none
module fcct_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_en_n,
  input wire logic iorq_n,
  input wire logic rd_n,
  input wire logic m1_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [2:0] zero_count_pulse,
  input wire logic irq_n_out,
  input wire logic irq_oe,
  input wire logic chain_enable_in,
  input wire logic chain_enable_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Acknowledge taken with chain priority and a live request
  sequence ack_take;
    $fell(iorq_n) && !m1_n && chain_enable_in && irq_oe;
  endsequence
  reset_idle_a: assert property (
    $fell(rst) |-> !data_oe && !irq_oe && zero_count_pulse == 3'h0
      && chain_enable_out == $past(chain_enable_in)) else $error("outputs busy after reset");
  ack_answer_a: assert property (
    ack_take |=> data_oe && !data_out[0]) else $error("vector missing on acknowledge");
  ack_service_a: assert property (
    ack_take |=> ##1 !chain_enable_out) else $error("chain open during service");
  ack_gate_a: assert property (
    !iorq_n && !m1_n && !chain_enable_in |=> !data_oe) else $error("vector without priority");
  read_answer_a: assert property (
    !chip_en_n && !iorq_n && !rd_n && m1_n |=> data_oe) else $error("read not answered");
  zc_pulse_a: assert property (
    zero_count_pulse != 3'h0 |=> (zero_count_pulse & $past(zero_count_pulse)) == 3'h0)
    else $error("zero pulse too long");
  chain_block_a: assert property (
    !chain_enable_in |=> !chain_enable_out) else $error("chain passed without input");
  irq_drain_a: assert property (
    irq_oe |-> !irq_n_out) else $error("request pin not pulled low");
endmodule
`default_nettype wire

// ### sim/fcct_host.sv
// Host processor model driving the counter/timer I/O bus
`default_nettype none
`include "fcct_defines.vh"
module fcct_host (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic chip_en_n,
  output logic iorq_n,
  output logic rd_n,
  output logic m1_n,
  output logic chan_sel_lo,
  output logic chan_sel_hi,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle at time zero
  initial
  begin
    {chip_en_n, iorq_n, rd_n, m1_n} = 4'hf;
    {chan_sel_hi, chan_sel_lo} = 2'h0;
    data_in = 8'h00;
  end
  // One byte written, then an idle cycle
  task automatic wr(input logic [1:0] ch, input logic [7:0] b);
    @(negedge clk);
    {chan_sel_hi, chan_sel_lo} = ch;
    data_in = b;
    {chip_en_n, iorq_n} = 2'h0;
    @(negedge clk);
    {chip_en_n, iorq_n} = 2'h3;
    data_in = ~b; // Released bus shows no stale byte
    @(negedge clk);
  endtask
  // Read held over two edges; undriven bus gives unknown
  task automatic rd(input logic [1:0] ch, output logic [7:0] b);
    @(negedge clk);
    {chan_sel_hi, chan_sel_lo} = ch;
    {chip_en_n, iorq_n, rd_n} = 3'h0;
    repeat (2) @(negedge clk);
    b = data_oe ? data_out : 8'hxx;
    {chip_en_n, iorq_n, rd_n} = 3'h7;
    @(negedge clk);
  endtask
  // Acknowledge; vector registered at the take edge and sampled at the next falling edge, odd marker if absent
  task automatic ack(output logic [7:0] b);
    @(negedge clk);
    {iorq_n, m1_n} = 2'h0;
    @(negedge clk);
    b = data_oe ? data_out : 8'h01;
    @(negedge clk);
    {iorq_n, m1_n} = 2'h3;
    @(negedge clk);
  endtask
  // Return opcode fetched on two back-to-back cycles
  task automatic return_from_irq_opcode;
    @(negedge clk);
    {m1_n, rd_n} = 2'h0;
    data_in = `FCCT_RETURN_FROM_IRQ_OPCODE_PREFIX;
    @(negedge clk);
    data_in = `FCCT_RETURN_FROM_IRQ_OPCODE_SECOND;
    @(negedge clk);
    {m1_n, rd_n} = 2'h3;
    data_in = ~data_in;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the four channel counter/timer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, chain_enable_in, chip_en_n, iorq_n, rd_n, m1_n, chan_sel_lo, chan_sel_hi;
  logic data_oe, irq_n_out, irq_oe, chain_enable_out;
  logic [7:0] data_in, data_out, v;
  logic [3:0] ext_clock_trigger;
  logic [2:0] zero_count_pulse;
  int fail_count, n_tests, n;
  int zc_n [3];
  fcct_top u_fcct_top (.clk(clk), .rst(rst), .chip_en_n(chip_en_n), .iorq_n(iorq_n),
    .rd_n(rd_n), .m1_n(m1_n), .chan_sel_lo(chan_sel_lo), .chan_sel_hi(chan_sel_hi),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ext_clock_trigger(ext_clock_trigger), .zero_count_pulse(zero_count_pulse),
    .irq_n_out(irq_n_out), .irq_oe(irq_oe), .chain_enable_in(chain_enable_in),
    .chain_enable_out(chain_enable_out));
  fcct_host u_fcct_host (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .chip_en_n(chip_en_n), .iorq_n(iorq_n), .rd_n(rd_n), .m1_n(m1_n),
    .chan_sel_lo(chan_sel_lo), .chan_sel_hi(chan_sel_hi), .data_in(data_in));
  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Zero pulses tallied per channel
  always @(negedge clk)
    foreach (zc_n[i]) zc_n[i] += zero_count_pulse[i];
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cycles up to the next zero pulse, bounded
  task automatic wait_zc(input int c);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (zero_count_pulse[c] !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      fail_count++;
      $display("unexpected at %0t: no zero pulse", $time);
      print_verdict;
    end
  endtask
  // One high then low pulse on the chosen external inputs
  task automatic pulse(input logic [3:0] m);
    ext_clock_trigger |= m;
    repeat (3) @(negedge clk);
    ext_clock_trigger &= ~m;
    repeat (3) @(negedge clk);
  endtask
  initial
  begin
    rst = 1'b1;
    chain_enable_in = 1'b1;
    ext_clock_trigger = 4'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(16'(data_oe), 16'h0000);
    chk(16'(irq_oe) | 16'(zero_count_pulse), 16'h0000);
    chk(16'(chain_enable_out), 16'h0001);
    $display("reset test done");
    u_fcct_host.wr(2'h1, 8'h55);
    u_fcct_host.wr(2'h1, 8'h03);
    u_fcct_host.rd(2'h1, v);
    chk(16'(v), 16'h0003);
    pulse(4'h2);
    u_fcct_host.rd(2'h1, v);
    chk(16'(v), 16'h0002);
    repeat (2) pulse(4'h2);
    u_fcct_host.rd(2'h1, v);
    chk(16'(v), 16'h0003);
    chk(16'(zc_n[1]), 16'h0001);
    u_fcct_host.wr(2'h2, 8'h45);
    u_fcct_host.wr(2'h2, 8'h00);
    u_fcct_host.rd(2'h2, v);
    chk(16'(v), 16'h0000);
    pulse(4'h4);
    u_fcct_host.rd(2'h2, v);
    chk(16'(v), 16'h00ff);
    u_fcct_host.wr(2'h1, 8'h53);
    repeat (3) pulse(4'h2);
    chk(16'(zc_n[1]), 16'h0001);
    $display("counter test done");
    u_fcct_host.wr(2'h0, 8'h05);
    u_fcct_host.wr(2'h0, 8'h02);
    repeat (2) wait_zc(0);
    chk(16'(n), 16'h0020);
    u_fcct_host.wr(2'h0, 8'h27);
    u_fcct_host.wr(2'h0, 8'h02);
    repeat (2) wait_zc(0);
    chk(16'(n), 16'h0200);
    u_fcct_host.wr(2'h0, 8'h03);
    u_fcct_host.wr(2'h0, 8'h0d);
    u_fcct_host.wr(2'h0, 8'h02);
    n = zc_n[0];
    repeat (40) @(negedge clk);
    chk(16'(zc_n[0]), 16'(n));
    pulse(4'h1);
    repeat (2) wait_zc(0);
    chk(16'(n), 16'h0020);
    u_fcct_host.wr(2'h0, 8'h03);
    $display("timer test done");
    u_fcct_host.wr(2'h0, 8'ha8);
    u_fcct_host.wr(2'h1, 8'hd7);
    u_fcct_host.wr(2'h1, 8'h01);
    u_fcct_host.wr(2'h2, 8'hd7);
    u_fcct_host.wr(2'h2, 8'h01);
    pulse(4'h6);
    chk(16'(irq_oe), 16'h0001);
    chain_enable_in = 1'b0;
    repeat (2) @(negedge clk);
    u_fcct_host.ack(v);
    chk(16'(v), 16'h0001);
    chain_enable_in = 1'b1;
    repeat (2) @(negedge clk);
    u_fcct_host.ack(v);
    chk(16'(v), 16'h00aa);
    chk(16'(chain_enable_out), 16'h0000);
    chk(16'(irq_oe), 16'h0000);
    u_fcct_host.return_from_irq_opcode;
    chk(16'(chain_enable_out), 16'h0001);
    u_fcct_host.ack(v);
    chk(16'(v), 16'h00ac);
    u_fcct_host.return_from_irq_opcode;
    $display("interrupt test done");
    print_verdict;
  end
endmodule
bind fcct_top fcct_properties u_fcct_properties (.clk(clk), .rst(rst), .chip_en_n(chip_en_n),
  .iorq_n(iorq_n), .rd_n(rd_n), .m1_n(m1_n), .data_out(data_out), .data_oe(data_oe),
  .zero_count_pulse(zero_count_pulse), .irq_n_out(irq_n_out), .irq_oe(irq_oe),
  .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out));
`default_nettype wire
